// ==== sys_irq_pkg.sv ====
/*
 * package for the system interrupt enable and flag registers: offsets, bit
 * positions, reset values and the byte bus request carrier.
 * assumes a byte-wide peripheral bus clocked by clk_sys.
 */
package sys_irq_pkg;
    // ==========================================================
    // address map
    localparam logic [15:0] REGION_BASE = 16'h0000;
    localparam logic [15:0] REGION_LAST = 16'h000F;
    localparam logic [15:0] PERIPH8_BASE = 16'h0010;
    localparam logic [15:0] OFS_ENABLE_1 = 16'h0000;
    localparam logic [15:0] OFS_ENABLE_2 = 16'h0001;
    localparam logic [15:0] OFS_FLAG_1 = 16'h0002;
    localparam logic [15:0] OFS_FLAG_2 = 16'h0003;
    // ==========================================================
    // enable register bits
    localparam int BIT_WDOG_IRQ_EN = 0;
    localparam int BIT_OSC_FAULT_IRQ_EN = 1;
    localparam int BIT_PIN_NMI_IRQ_EN = 4;
    localparam int BIT_FLASH_VIOL_IRQ_EN = 5;
    localparam logic [7:0] ENABLE_1_MASK = 8'h33;
    localparam logic [7:0] ENABLE_1_RESET = 8'h00;
    // ==========================================================
    // flag register bits
    localparam int BIT_WDOG_EVENT_FLAG = 0;
    localparam int BIT_OSC_FAULT_FLAG = 1;
    localparam int BIT_POWER_ON_FLAG = 2;
    localparam int BIT_EXT_RESET_FLAG = 3;
    localparam int BIT_PIN_NMI_FLAG = 4;
    localparam logic [7:0] FLAG_1_MASK = 8'h1F;
    localparam logic [7:0] FLAG_1_POR_RESET = 8'h04;
    localparam logic [7:0] FLAG_1_PUC_RESET = 8'h02;
    // ==========================================================
    // nmi vector and priority, consumed by the vector logic outside
    localparam logic [15:0] NMI_VECTOR_ADDR = 16'hFFFC;
    localparam logic [4:0] NMI_PRIORITY = 5'h1E;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } byte_req_t;
endpackage

// ==== system_irq_enable_flag_regs.sv ====
/*
 * system interrupt enable and flag registers at the bottom of the map.
 * assumes: single-cycle byte bus from the cpu, event inputs are one-cycle
 * pulses on clk_sys, rst_n is the raw power-on reset, puc a one-cycle
 * synchronous power-up-clear pulse from the reset logic.
 */
// What this block does
// - source enable gates its nmi request; the global enable has no say
// - only defined bit positions are real flip-flops
// - enable reg at 00h: bits 0,1,4,5, read/write, cleared by puc
// - watchdog enable gates its request only in interval timer mode
// - flag reg at 02h: bits 0..4 as listed, read/write
// - por bits reset only on por, puc bits on every puc
// - por clears wdog and ext reset, sets power on; puc sets osc, clears nmi
// - watchdog flag set on overflow in watchdog mode or key violation
// - watchdog flag cleared on power-on and on pin reset
// - oscillator fault flag set on each detected fault
// - ext reset flag set on pin reset, cleared on power-up
// - pin nmi flag set on a pin nmi event
// - flags of other peripherals live in their own modules
// - region decodes 0x0000..0x000F, below the 8-bit peripheral space
// - nmi, osc fault, flash violation share vector 0xFFFC, priority 30
`timescale 1ns/1ps
`default_nettype none
module system_irq_enable_flag_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_up_clear,
    input wire sys_irq_pkg::byte_req_t bus_req,
    output logic [7:0] bus_rdata,
    output logic region_hit,
    input wire logic wdog_interval_mode,
    input wire logic wdog_overflow,
    input wire logic wdog_interval_event,
    input wire logic key_violation,
    input wire logic osc_fault_detect,
    input wire logic pin_reset_event,
    input wire logic pin_nmi_event,
    input wire logic flash_viol_req,
    output logic wdog_irq_req,
    output logic nmi_req
);
    import sys_irq_pkg::*;

    // ==========================================================
    // reset release
    logic rst_s1_q;
    logic rst_s2_q;
    // two stages keep the release glitch free against clk_sys
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_sync_n = rst_s2_q;

    // ==========================================================
    // decode
    function automatic logic hit_at(input logic [15:0] a, input logic [15:0] ofs);
        hit_at = (a == ofs);
    endfunction
    wire logic in_region = bus_req.sel && (bus_req.addr <= REGION_LAST);
    // a single byte bus: at most one of the strobes below is high in any cycle
    wire logic wr_en1 = in_region && bus_req.wr && hit_at(bus_req.addr, OFS_ENABLE_1);
    wire logic wr_flg1 = in_region && bus_req.wr && hit_at(bus_req.addr, OFS_FLAG_1);
    wire logic rd_en1 = in_region && !bus_req.wr && hit_at(bus_req.addr, OFS_ENABLE_1);
    wire logic rd_flg1 = in_region && !bus_req.wr && hit_at(bus_req.addr, OFS_FLAG_1);
    assign region_hit = in_region;

    // ==========================================================
    // enable bits: only four flip-flops exist
    logic wdog_irq_en_q;
    logic osc_fault_irq_en_q;
    logic pin_nmi_irq_en_q;
    logic flash_viol_irq_en_q;
    // puc is tested ahead of the write, so a clear and a write together leave zeros
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdog_irq_en_q <= ENABLE_1_RESET[BIT_WDOG_IRQ_EN];
            osc_fault_irq_en_q <= ENABLE_1_RESET[BIT_OSC_FAULT_IRQ_EN];
            pin_nmi_irq_en_q <= ENABLE_1_RESET[BIT_PIN_NMI_IRQ_EN];
            flash_viol_irq_en_q <= ENABLE_1_RESET[BIT_FLASH_VIOL_IRQ_EN];
        end else if (power_up_clear) begin
            wdog_irq_en_q <= ENABLE_1_RESET[BIT_WDOG_IRQ_EN];
            osc_fault_irq_en_q <= ENABLE_1_RESET[BIT_OSC_FAULT_IRQ_EN];
            pin_nmi_irq_en_q <= ENABLE_1_RESET[BIT_PIN_NMI_IRQ_EN];
            flash_viol_irq_en_q <= ENABLE_1_RESET[BIT_FLASH_VIOL_IRQ_EN];
        end else if (wr_en1) begin
            wdog_irq_en_q <= bus_req.wdata[BIT_WDOG_IRQ_EN];
            osc_fault_irq_en_q <= bus_req.wdata[BIT_OSC_FAULT_IRQ_EN];
            pin_nmi_irq_en_q <= bus_req.wdata[BIT_PIN_NMI_IRQ_EN];
            flash_viol_irq_en_q <= bus_req.wdata[BIT_FLASH_VIOL_IRQ_EN];
        end
    end

    // ==========================================================
    // flag bits; hardware set wins over a software write of zero
    logic wdog_event_flag_q;
    logic osc_fault_flag_q;
    logic power_on_flag_q;
    logic ext_reset_flag_q;
    logic pin_nmi_flag_q;
    // watchdog-mode overflow or key violation sets; interval events are the timer's own
    wire logic wdog_set = (wdog_overflow && !wdog_interval_mode) || key_violation;
    // ext reset and the other por bits ignore puc: only rst_n restores them
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdog_event_flag_q <= FLAG_1_POR_RESET[BIT_WDOG_EVENT_FLAG];
            power_on_flag_q <= FLAG_1_POR_RESET[BIT_POWER_ON_FLAG];
            ext_reset_flag_q <= FLAG_1_POR_RESET[BIT_EXT_RESET_FLAG];
        end else begin
            if (pin_reset_event) begin
                wdog_event_flag_q <= 1'b0;
            end else if (wdog_set) begin
                wdog_event_flag_q <= 1'b1;
            end else if (wr_flg1) begin
                wdog_event_flag_q <= bus_req.wdata[BIT_WDOG_EVENT_FLAG];
            end
            if (wr_flg1) begin
                power_on_flag_q <= bus_req.wdata[BIT_POWER_ON_FLAG];
            end
            if (pin_reset_event) begin
                ext_reset_flag_q <= 1'b1;
            end else if (wr_flg1) begin
                ext_reset_flag_q <= bus_req.wdata[BIT_EXT_RESET_FLAG];
            end
        end
    end

    // puc-initialised flags: oscillator fault and pin nmi
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_fault_flag_q <= FLAG_1_PUC_RESET[BIT_OSC_FAULT_FLAG];
            pin_nmi_flag_q <= FLAG_1_PUC_RESET[BIT_PIN_NMI_FLAG];
        end else if (power_up_clear) begin
            osc_fault_flag_q <= FLAG_1_PUC_RESET[BIT_OSC_FAULT_FLAG];
            pin_nmi_flag_q <= FLAG_1_PUC_RESET[BIT_PIN_NMI_FLAG];
        end else begin
            if (osc_fault_detect) begin
                osc_fault_flag_q <= 1'b1;
            end else if (wr_flg1) begin
                osc_fault_flag_q <= bus_req.wdata[BIT_OSC_FAULT_FLAG];
            end
            if (pin_nmi_event) begin
                pin_nmi_flag_q <= 1'b1;
            end else if (wr_flg1) begin
                pin_nmi_flag_q <= bus_req.wdata[BIT_PIN_NMI_FLAG];
            end
        end
    end

    // ==========================================================
    // register images; unused bits are constant zero, not storage
    wire logic [7:0] enable_1_img = {2'b00, flash_viol_irq_en_q, pin_nmi_irq_en_q, 2'b00,
                                     osc_fault_irq_en_q, wdog_irq_en_q};
    wire logic [7:0] flag_1_img = {3'b000, pin_nmi_flag_q, ext_reset_flag_q,
                                   power_on_flag_q, osc_fault_flag_q, wdog_event_flag_q};
    // second registers and the rest of the region read zero
    wire logic [7:0] rd_mux = rd_en1 ? (enable_1_img & ENABLE_1_MASK) :
                              rd_flg1 ? (flag_1_img & FLAG_1_MASK) : 8'h00;
    // registered read data: valid in the cycle after the request, zero otherwise
    logic [7:0] rdata_q;
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_mux;
        end
    end
    assign bus_rdata = rdata_q;

    // ==========================================================
    // requests; no global interrupt enable input exists, so it cannot mask
    assign nmi_req = (pin_nmi_flag_q && pin_nmi_irq_en_q) ||
                     (osc_fault_flag_q && osc_fault_irq_en_q) ||
                     (flash_viol_req && flash_viol_irq_en_q);
    // interval events are flagged inside the timer; enable only gates them there
    assign wdog_irq_req = wdog_interval_mode && wdog_interval_event && wdog_irq_en_q;

    // ==========================================================
    // checks; every property runs on clk_sys and sleeps while reset is held
    // request gating: each source enable masks only its own share of the line
    chk_nmi_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (pin_nmi_flag_q && pin_nmi_irq_en_q) |-> nmi_req)
        else $error("nmi request missing");
    chk_nmi_block: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (!pin_nmi_irq_en_q && !osc_fault_irq_en_q && !flash_viol_irq_en_q) |-> !nmi_req)
        else $error("nmi request while disabled");
    chk_osc_masked: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (osc_fault_flag_q && !osc_fault_irq_en_q && !pin_nmi_flag_q && !flash_viol_req) |-> !nmi_req)
        else $error("masked osc fault raised nmi");
    chk_flash_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (flash_viol_req && flash_viol_irq_en_q) |-> nmi_req)
        else $error("flash violation request missing");
    // watchdog enable matters only when the timer runs in interval mode
    chk_wdog_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        !wdog_interval_mode |-> !wdog_irq_req)
        else $error("watchdog irq in reset mode");
    chk_wdog_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (wdog_interval_mode && !wdog_irq_en_q) |-> !wdog_irq_req)
        else $error("watchdog irq while disabled");
    // power-up clear: its own bits reset, the power on and ext reset flags kept
    chk_puc_enable: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        power_up_clear |=> (enable_1_img == 8'h00))
        else $error("enable not cleared by puc");
    chk_puc_flags: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        power_up_clear |=> (osc_fault_flag_q && !pin_nmi_flag_q))
        else $error("puc flags wrong");
    chk_puc_keeps_por: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (power_up_clear && !wr_flg1 && !pin_reset_event) |=> $stable(power_on_flag_q))
        else $error("por flag disturbed by puc");
    chk_puc_keeps_ext: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (power_up_clear && !wr_flg1 && !pin_reset_event) |=> $stable(ext_reset_flag_q))
        else $error("ext reset flag disturbed by puc");
    // hardware set and clear paths
    chk_wdog_set: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (key_violation && !pin_reset_event) |=> wdog_event_flag_q)
        else $error("watchdog flag not set");
    chk_wdog_overflow: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (wdog_overflow && !wdog_interval_mode && !pin_reset_event) |=> wdog_event_flag_q)
        else $error("watchdog overflow not flagged");
    chk_pin_reset: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        pin_reset_event |=> (ext_reset_flag_q && !wdog_event_flag_q))
        else $error("pin reset flags wrong");
    chk_osc_set: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        osc_fault_detect |=> osc_fault_flag_q)
        else $error("osc fault flag not set");
    chk_nmi_set: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (pin_nmi_event && !power_up_clear) |=> pin_nmi_flag_q)
        else $error("nmi flag not set");
    chk_flag_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (pin_nmi_flag_q && !wr_flg1 && !power_up_clear) |=> pin_nmi_flag_q)
        else $error("nmi flag dropped");
    // software access: writes land, reads return the image of the request cycle
    chk_en_write: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (wr_en1 && !power_up_clear) |=> (enable_1_img == ($past(bus_req.wdata) & ENABLE_1_MASK)))
        else $error("enable write lost");
    chk_por_write: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        wr_flg1 |=> (power_on_flag_q == $past(bus_req.wdata[BIT_POWER_ON_FLAG])))
        else $error("power on flag write lost");
    chk_ext_write: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (wr_flg1 && bus_req.wdata[BIT_EXT_RESET_FLAG]) |=> ext_reset_flag_q)
        else $error("ext reset flag write lost");
    chk_flag_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (wr_flg1 && !bus_req.wdata[BIT_PIN_NMI_FLAG] && !pin_nmi_event) |=> !pin_nmi_flag_q)
        else $error("nmi flag not cleared by write");
    chk_en_read: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        rd_en1 |=> (bus_rdata == $past(enable_1_img)))
        else $error("enable read wrong");
    chk_flag_read: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        rd_flg1 |=> (bus_rdata == $past(flag_1_img)))
        else $error("flag read wrong");
    // the rest of the region is inert and the space beyond it is not decoded here
    chk_rsvd_read: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (in_region && !bus_req.wr && !hit_at(bus_req.addr, OFS_ENABLE_1)
         && !hit_at(bus_req.addr, OFS_FLAG_1)) |=> (bus_rdata == 8'h00))
        else $error("reserved read not zero");
    chk_rsvd_write: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (in_region && bus_req.wr && hit_at(bus_req.addr, OFS_ENABLE_2) && !power_up_clear)
        |=> $stable(enable_1_img))
        else $error("reserved write changed enables");
    chk_outside: assert property (
        @(posedge clk_sys) disable iff (!rst_sync_n)
        (bus_req.sel && (bus_req.addr >= PERIPH8_BASE)) |-> !region_hit)
        else $error("peripheral space decoded as region");
    // main scenarios
    cov_nmi: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) nmi_req);
    cov_wdog: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) wdog_irq_req);
    cov_set_clear: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
        pin_nmi_event && wr_flg1);
    cov_puc: cover property (@(posedge clk_sys) disable iff (!rst_sync_n) power_up_clear);
    cov_flash_nmi: cover property (@(posedge clk_sys) disable iff (!rst_sync_n)
        nmi_req && flash_viol_req);
endmodule
`default_nettype wire

// ==== cpu_bus_model.sv ====
/*
 * cpu side byte bus master model for the system interrupt registers.
 * assumes every call starts just after a rising edge of clk_sys; an access
 * takes two cycles, the request and then a released bus.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    input wire logic clk_sys,
    output var sys_irq_pkg::byte_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic region_hit
);
    import sys_irq_pkg::*;
    // ==========================================================
    // bus cycles
    initial begin
        bus_req = '0;
    end
    // request held through the taking edge, read data caught just after it
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic h);
        bus_req = '{sel: 1'b1, wr: w, addr: a, wdata: d};
        #1 h = region_hit;
        @(posedge clk_sys);
        #1 q = bus_rdata;
        // release so a lingering write never repeats at a later edge
        idle();
    endtask
    // released lines show the inverse so a stale value never looks valid
    task automatic idle();
        bus_req = '{sel: 1'b0, wr: ~bus_req.wr, addr: ~bus_req.addr, wdata: ~bus_req.wdata};
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

// ==== system_irq_enable_flag_regs_tb_top.sv ====
/*
 * self-checking bench for the system interrupt enable and flag registers.
 * assumes the cpu bus model drives the byte bus; events are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module system_irq_enable_flag_regs_tb_top;
    import sys_irq_pkg::*;
    typedef struct {logic [15:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
    logic clk_sys, rst_n, power_up_clear, wmode, fviol, region_hit, wdog_irq_req, nmi_req, h;
    logic [5:0] evt; // overflow, interval, key, osc, pin reset, pin nmi
    logic [7:0] bus_rdata, q;
    byte_req_t bus_req;
    int num_errors, n_compared, cycles;
    row_t rows[7];
    // ==========================================================
    // design and cpu model
    system_irq_enable_flag_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .power_up_clear(power_up_clear),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .region_hit(region_hit),
        .wdog_interval_mode(wmode), .wdog_overflow(evt[0]), .wdog_interval_event(evt[1]),
        .key_violation(evt[2]), .osc_fault_detect(evt[3]), .pin_reset_event(evt[4]),
        .pin_nmi_event(evt[5]), .flash_viol_req(fviol), .wdog_irq_req(wdog_irq_req),
        .nmi_req(nmi_req));
    cpu_bus_model cpu (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .region_hit(region_hit));
    // ==========================================================
    // helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a);
        cpu.access(1'b0, a, 8'h00, q, h);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu.access(1'b1, a, d, q, h);
    endtask
    task automatic pulse(input int i);
        evt[i] = 1'b1;
        @(posedge clk_sys);
        #1 evt[i] = 1'b0;
    endtask
    task automatic reset_dut(input int n);
        rst_n = 1'b0;
        repeat (n) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk_sys); // first request taken on the fourth edge after release
        #1;
    endtask
    task automatic final_report();
        $display("compares %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================
    // clock and hang guard; a run needs well under 400 cycles
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        {power_up_clear, wmode, fviol, evt} = '0;
        // osc fault enable bit kept at zero by software
        rows = '{'{16'h0000, 8'hFD, 8'h31}, '{16'h0001, 8'hFF, 8'h00},
                 '{16'h0003, 8'hFF, 8'h00}, '{16'h000F, 8'hFF, 8'h00},
                 '{16'h0002, 8'h00, 8'h00}, '{16'h0002, 8'hFF, 8'h1F},
                 '{16'h0002, 8'h00, 8'h00}};
        reset_dut(2);
        rd(16'h0000); check(q, 8'h00);
        rd(16'h0002); check(q, 8'h06);
        rd(16'h000F); check({7'd0, h}, 8'h01);
        rd(16'h0010); check({7'd0, h}, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr);
            check(q, rows[i].exp);
        end
        // hardware events into the flag register, each sticking until cleared
        pulse(0); rd(16'h0002); check(q, 8'h01);
        wr(16'h0002, 8'h00); pulse(2); rd(16'h0002); check(q, 8'h01);
        pulse(4); rd(16'h0002); check(q, 8'h08);
        pulse(3); rd(16'h0002); check(q, 8'h0A);
        pulse(5); rd(16'h0002); check(q, 8'h1A);
        check({7'd0, nmi_req}, 8'h01);
        wr(16'h0000, 8'h21); check({7'd0, nmi_req}, 8'h00);
        fviol = 1'b1; #1 check({7'd0, nmi_req}, 8'h01);
        wr(16'h0000, 8'h00); check({7'd0, nmi_req}, 8'h00);
        fviol = 1'b0;
        // overflow counts only in watchdog mode; enable counts only in interval mode
        wmode = 1'b1; wr(16'h0002, 8'h00); pulse(0); rd(16'h0002); check(q, 8'h00);
        wr(16'h0000, 8'h01); evt[1] = 1'b1; #1 check({7'd0, wdog_irq_req}, 8'h01);
        wmode = 1'b0; #1 check({7'd0, wdog_irq_req}, 8'h00);
        evt[1] = 1'b0;
        // power-up clear touches only its own bits
        wr(16'h0002, 8'h1D);
        power_up_clear = 1'b1;
        @(posedge clk_sys);
        #1 power_up_clear = 1'b0;
        rd(16'h0000); check(q, 8'h00);
        rd(16'h0002); check(q, 8'h0F);
        cpu.idle();
        reset_dut(1);
        rd(16'h0002); check(q, 8'h06);
        // a pin nmi event held through a software clear and the released cycle after it: the flag ends set
        evt[5] = 1'b1;
        wr(16'h0002, 8'h00);
        evt[5] = 1'b0;
        rd(16'h0002); check(q, 8'h10);
        final_report();
    end
endmodule
`default_nettype wire
